/* File: hw/interval_timer_consts.svh */
`ifndef INTERVAL_TIMER_CONSTS_SVH
`define INTERVAL_TIMER_CONSTS_SVH

`define ADDR_MODE        12'h000
`define ADDR_COMPARE_A   12'h004
`define ADDR_COMPARE_B   12'h008
`define ADDR_IRQ_STATUS  12'h00C
`define ADDR_IRQ_MASK    12'h010
`define ADDR_COUNT_A     12'h014
`define ADDR_COUNT_B     12'h018

`define MODE_RESET       8'hFF
`define COMPARE_RESET    8'h00
`define MASK_RESET       2'h0

`define MODE_TOGGLE_LO   0
`define MODE_TOGGLE_HI   1
`define MODE_A_CLK_LO    2
`define MODE_A_CLK_HI    3
`define MODE_A_HALT      4
`define MODE_B_CLK_LO    5
`define MODE_B_CLK_HI    6
`define MODE_B_HALT      7

`define DIV_FAST         3
`define DIV_MID          12
`define DIV_SLOW         384
`define DIV3_W           2
`define PRESCALE_W       5
`define PRESCALE_LAST    5'h1F

`endif

/* File: hw/interval_timer_pkg.sv */
package interval_timer_pkg;

    typedef enum logic [1:0]
    {
        CLK_DIV12  = 2'h0,
        CLK_DIV384 = 2'h1,
        CLK_EXT    = 2'h2,
        CLK_ALT    = 2'h3
    } count_src_t;

    typedef enum logic [1:0]
    {
        TGL_MATCH_A = 2'h0,
        TGL_MATCH_B = 2'h1,
        TGL_DIV3    = 2'h2,
        TGL_RESET   = 2'h3
    } toggle_src_t;

    typedef enum logic [2:0]
    {
        EXT_LOW  = 3'h1,
        EXT_HIGH = 3'h2,
        EXT_FALL = 3'h4
    } ext_state_t;

endpackage

/* File: hw/clock_prescaler.sv */
`timescale 1ns/1ps
`include "interval_timer_consts.svh"

// produces one-cycle ticks at clk/3, clk/12 and clk/384
module clock_prescaler
(
    input  wire logic clk,
    input  wire logic rst_b,
    output logic      tick_div3,
    output logic      tick_div12,
    output logic      tick_div384
);

    logic [`DIV3_W-1:0]     div3_cnt;
    logic [1:0]             quarter_cnt;
    logic [`PRESCALE_W-1:0] slow_cnt;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            div3_cnt <= '0;
        else if (div3_cnt == `DIV3_W'(`DIV_FAST - 1))
            div3_cnt <= '0;
        else
            div3_cnt <= div3_cnt + 1'b1;
    end

    assign tick_div3 = (div3_cnt == `DIV3_W'(`DIV_FAST - 1));

    // 12 = 3 * 4, 384 = 12 * 32 chained so all ticks stay phase-aligned
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            quarter_cnt <= '0;
        else if (tick_div3)
            quarter_cnt <= quarter_cnt + 1'b1;
    end

    assign tick_div12 = tick_div3 && (quarter_cnt == 2'h3);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            slow_cnt <= '0;
        else if (tick_div12)
            slow_cnt <= slow_cnt + 1'b1;
    end

    // five bits wrap after 32 slow steps, so no terminal reload is needed
    assign tick_div384 = tick_div12 && (slow_cnt == `PRESCALE_LAST);

endmodule // clock_prescaler

/* File: hw/ext_count_filter.sv */
`timescale 1ns/1ps
`include "interval_timer_consts.svh"

// samples the count pin on each div3 tick; a level must be seen twice in a row
module ext_count_filter
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic sample_tick,
    input  wire logic ext_count_pin,
    output logic      fall_event
);

    logic                          last_sample;
    interval_timer_pkg::ext_state_t state;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            last_sample <= 1'b1;
        else if (sample_tick)
            last_sample <= ext_count_pin;
    end

    // idle high, so a pin held low through reset gives a fall edge after two low samples
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            state <= interval_timer_pkg::EXT_HIGH;
        else if (sample_tick)
        begin
            case (state)
                interval_timer_pkg::EXT_HIGH:
                    if (!ext_count_pin && !last_sample)
                        state <= interval_timer_pkg::EXT_FALL;
                interval_timer_pkg::EXT_FALL:
                    state <= interval_timer_pkg::EXT_LOW;
                interval_timer_pkg::EXT_LOW:
                    if (ext_count_pin && last_sample)
                        state <= interval_timer_pkg::EXT_HIGH;
                default:
                    state <= interval_timer_pkg::EXT_HIGH;
            endcase
        end
    end

    assign fall_event = sample_tick && (state == interval_timer_pkg::EXT_FALL);

endmodule // ext_count_filter

/* File: hw/dual_interval_timer_toggle.sv */
`timescale 1ns/1ps
`include "interval_timer_consts.svh"

// Function
// - two timers, 8-bit counter, comparator, interval
// - match clears counter and raises interrupt
// - toggle flop inverts on selected source
// - mode bits 1:0 pick toggle source
// - toggle clock is oscillator divided by three
// - count clocks are divide twelve and 384
// - mode bits 3:2 pick timer a clock
// - bit 4 high holds a cleared; fall restarts
// - rewriting zero keeps running count intact
// - mode bits 6:5 pick b clock, cascade
// - bit 7 halts b like bit 4
// - reset loads ones, clears counters, toggle
// - toggle feeds event timebase and serial clock
// - timer times oscillator settling on wake
// - interval write suppresses that match
// - interval zero matches every 256 counts
// - count pin filtered, two equal samples
module dual_interval_timer_toggle
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_count_pin,
    output logic             toggle_out_pin,
    output logic             toggle_timebase,
    output logic             a_match_irq,
    output logic             b_match_irq,
    output logic             irq
);

    logic [7:0] timer_control_mode;
    logic [7:0] interval_compare_a;
    logic [7:0] interval_compare_b;
    logic [7:0] count_a;
    logic [7:0] count_b;
    logic       halt_a_prev;
    logic       halt_b_prev;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic       toggle_ff;
    logic       tick_div3;
    logic       tick_div12;
    logic       tick_div384;
    logic       ext_fall;
    logic       wr_en;
    logic       rd_en;
    logic       hit;
    logic       wr_cmp_a;
    logic       wr_cmp_b;
    logic       count_en_a;
    logic       count_en_b;
    logic       match_a;
    logic       match_b;
    logic       clear_status;
    logic [31:0] next_prdata;

    interval_timer_pkg::count_src_t  a_clock_sel;
    interval_timer_pkg::count_src_t  b_clock_sel;
    interval_timer_pkg::toggle_src_t toggle_sel;

    clock_prescaler u_prescaler
    (
        .clk         (clk),
        .rst_b       (rst_b),
        .tick_div3   (tick_div3),
        .tick_div12  (tick_div12),
        .tick_div384 (tick_div384)
    );

    ext_count_filter u_ext_filter
    (
        .clk           (clk),
        .rst_b         (rst_b),
        .sample_tick   (tick_div3),
        .ext_count_pin (ext_count_pin),
        .fall_event    (ext_fall)
    );

    // single-cycle slave: pready is always high, unmapped reads return zero
    assign pready  = 1'b1;
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;

    function automatic logic addr_mapped(input logic [11:0] a);
        addr_mapped = (a == `ADDR_MODE) || (a == `ADDR_COMPARE_A) ||
                      (a == `ADDR_COMPARE_B) || (a == `ADDR_IRQ_STATUS) ||
                      (a == `ADDR_IRQ_MASK) || (a == `ADDR_COUNT_A) ||
                      (a == `ADDR_COUNT_B);
    endfunction

    assign hit      = addr_mapped(paddr);
    assign pslverr  = psel && penable && !hit;
    assign wr_cmp_a = wr_en && (paddr == `ADDR_COMPARE_A);
    assign wr_cmp_b = wr_en && (paddr == `ADDR_COMPARE_B);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            timer_control_mode <= `MODE_RESET;
        else if (wr_en && (paddr == `ADDR_MODE))
            timer_control_mode <= pwdata[7:0];
    end

    // interval registers are undefined after reset in the original; zero here
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            interval_compare_a <= `COMPARE_RESET;
            interval_compare_b <= `COMPARE_RESET;
        end
        else
        begin
            if (wr_cmp_a)
                interval_compare_a <= pwdata[7:0];
            if (wr_cmp_b)
                interval_compare_b <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            irq_mask <= `MASK_RESET;
        else if (wr_en && (paddr == `ADDR_IRQ_MASK))
            irq_mask <= pwdata[1:0];
    end

    assign a_clock_sel = interval_timer_pkg::count_src_t'(
        timer_control_mode[`MODE_A_CLK_HI:`MODE_A_CLK_LO]);
    assign b_clock_sel = interval_timer_pkg::count_src_t'(
        timer_control_mode[`MODE_B_CLK_HI:`MODE_B_CLK_LO]);
    assign toggle_sel  = interval_timer_pkg::toggle_src_t'(
        timer_control_mode[`MODE_TOGGLE_HI:`MODE_TOGGLE_LO]);

    function automatic logic pick_tick(
        input interval_timer_pkg::count_src_t sel,
        input logic                           t12,
        input logic                           t384,
        input logic                           ext,
        input logic                           alt);
        case (sel)
            interval_timer_pkg::CLK_DIV12:  pick_tick = t12;
            interval_timer_pkg::CLK_DIV384: pick_tick = t384;
            interval_timer_pkg::CLK_EXT:    pick_tick = ext;
            default:                        pick_tick = alt;
        endcase
    endfunction

    // code 3 for timer a means disabled, for timer b it cascades on a's match
    assign count_en_a = pick_tick(a_clock_sel, tick_div12, tick_div384,
                                  ext_fall, 1'b0);
    assign count_en_b = pick_tick(b_clock_sel, tick_div12, tick_div384,
                                  ext_fall, match_a);

    // a match is the count event that would reach the interval; a value of
    // zero therefore matches on the wrap after 256 events
    assign match_a = count_en_a && !timer_control_mode[`MODE_A_HALT] &&
                     (count_a + 8'h01 == interval_compare_a) && !wr_cmp_a;
    assign match_b = count_en_b && !timer_control_mode[`MODE_B_HALT] &&
                     (count_b + 8'h01 == interval_compare_b) && !wr_cmp_b;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            halt_a_prev <= 1'b1;
            halt_b_prev <= 1'b1;
        end
        else
        begin
            halt_a_prev <= timer_control_mode[`MODE_A_HALT];
            halt_b_prev <= timer_control_mode[`MODE_B_HALT];
        end
    end

    // a halted counter already sits at zero, so a 1->0 change restarts from
    // zero and a repeated zero write leaves the count alone
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            count_a <= 8'h00;
        else if (timer_control_mode[`MODE_A_HALT] || halt_a_prev)
            count_a <= 8'h00;
        else if (match_a)
            count_a <= 8'h00;
        else if (count_en_a)
            count_a <= count_a + 8'h01;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            count_b <= 8'h00;
        else if (timer_control_mode[`MODE_B_HALT] || halt_b_prev)
            count_b <= 8'h00;
        else if (match_b)
            count_b <= 8'h00;
        else if (count_en_b)
            count_b <= count_b + 8'h01;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            toggle_ff <= 1'b0;
        else
        begin
            case (toggle_sel)
                interval_timer_pkg::TGL_MATCH_A:
                    toggle_ff <= toggle_ff ^ match_a;
                interval_timer_pkg::TGL_MATCH_B:
                    toggle_ff <= toggle_ff ^ match_b;
                interval_timer_pkg::TGL_DIV3:
                    toggle_ff <= toggle_ff ^ tick_div3;
                default:
                    toggle_ff <= 1'b0;
            endcase
        end
    end

    // pin routing lives outside; the timebase copy ignores it and also
    // serves as the settle-time base on standby exit
    assign toggle_out_pin  = toggle_ff;
    assign toggle_timebase = toggle_ff;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            a_match_irq <= 1'b0;
            b_match_irq <= 1'b0;
        end
        else
        begin
            a_match_irq <= match_a;
            b_match_irq <= match_b;
        end
    end

    assign clear_status = rd_en && (paddr == `ADDR_IRQ_STATUS);

    // set beats the read-clear so a match in the read cycle survives
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            irq_status <= 2'h0;
        else
            irq_status <= (clear_status ? 2'h0 : irq_status) | {match_b, match_a};
    end

    assign irq = |(irq_status & irq_mask);

    always_comb
    begin
        next_prdata = 32'h0000_0000;
        if (paddr == `ADDR_MODE)
            next_prdata[7:0] = timer_control_mode;
        else if (paddr == `ADDR_COMPARE_A)
            next_prdata[7:0] = interval_compare_a;
        else if (paddr == `ADDR_COMPARE_B)
            next_prdata[7:0] = interval_compare_b;
        else if (paddr == `ADDR_IRQ_STATUS)
            next_prdata[1:0] = irq_status;
        else if (paddr == `ADDR_IRQ_MASK)
            next_prdata[1:0] = irq_mask;
        else if (paddr == `ADDR_COUNT_A)
            next_prdata[7:0] = count_a;
        else if (paddr == `ADDR_COUNT_B)
            next_prdata[7:0] = count_b;
    end

    // read data registered during setup so it is stable in the access phase
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
            prdata <= next_prdata;
    end

endmodule // dual_interval_timer_toggle

/* File: verif/timer_properties.sv */
`timescale 1ns/1ps
`include "interval_timer_consts.svh"

module timer_properties
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        ext_count_pin,
    input wire logic        toggle_out_pin,
    input wire logic        toggle_timebase,
    input wire logic        a_match_irq,
    input wire logic        b_match_irq,
    input wire logic        irq
);
    // shadows of the writable mode and mask, rebuilt from bus traffic
    logic [7:0] mode_sh;
    logic [1:0] mask_sh;
    wire        wr_done = psel && penable && pwrite && pready;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_sh <= `MODE_RESET;
            mask_sh <= `MASK_RESET;
        end
        else if (wr_done && paddr == `ADDR_MODE)
            mode_sh <= pwdata[7:0];
        else if (wr_done && paddr == `ADDR_IRQ_MASK)
            mask_sh <= pwdata[1:0];
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_timebase_same: assert property (toggle_timebase == toggle_out_pin)
        else $error("timebase feed differs from toggle pin");
    a_toggle_held: assert property (mode_sh[1:0] == 2'h3 && $past(mode_sh[1:0]) == 2'h3
        |-> !toggle_out_pin)
        else $error("toggle not held low in reset code");
    a_toggle_match: assert property (mode_sh[1:0] == 2'h0 && $past(mode_sh[1:0]) == 2'h0
        && $changed(toggle_out_pin) |-> ##[0:1] a_match_irq)
        else $error("toggle moved without a timer a match");
    a_div3_rate: assert property (mode_sh[1:0] == 2'h2 && $past(mode_sh[1:0]) == 2'h2
        && $changed(toggle_out_pin) |-> ##3 ($changed(toggle_out_pin) || mode_sh[1:0] != 2'h2))
        else $error("toggle not inverted every third cycle");
    a_irq_follows: assert property (a_match_irq && mask_sh[0] |-> ##[0:1] irq)
        else $error("unmasked match gave no interrupt");
    a_irq_masked: assert property (irq |-> mask_sh != 2'h0)
        else $error("interrupt raised with all sources masked");
    a_halt_a: assert property (mode_sh[4] && $past(mode_sh[4], 2) |-> !a_match_irq)
        else $error("timer a matched while halted");
    a_halt_b: assert property (mode_sh[7] && $past(mode_sh[7], 2) |-> !b_match_irq)
        else $error("timer b matched while halted");
    a_cmp_write_quiet: assert property (psel && penable && pwrite &&
        paddr == `ADDR_COMPARE_A |=> !a_match_irq)
        else $error("match pulse after interval write");
    a_unmapped_err: assert property (psel && penable && paddr[1:0] == 2'h0
        |-> pslverr == (paddr > `ADDR_COUNT_B))
        else $error("error response wrong for address");
endmodule // timer_properties

bind dual_interval_timer_toggle timer_properties u_props
(
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_pin(ext_count_pin), .toggle_out_pin(toggle_out_pin),
    .toggle_timebase(toggle_timebase), .a_match_irq(a_match_irq),
    .b_match_irq(b_match_irq), .irq(irq)
);

/* File: verif/apb_master.sv */
`timescale 1ns/1ps

module apb_master
(
    input  wire logic        clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial
    begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // the request stands until pready is seen high; only the bench timeout ends a stall
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        do
            @(posedge clk);
        while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
endmodule // apb_master

/* File: verif/dual_interval_timer_toggle_tb.sv */
`timescale 1ns/1ps
`include "interval_timer_consts.svh"

module dual_interval_timer_toggle_tb;
    logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, ext_count_pin;
    logic        toggle_out_pin, toggle_timebase, a_match_irq, b_match_irq, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int          failures, checks_done, cyc;

`define CHECK(g, e) \
    begin \
        checks_done++; \
        if ((g) !== (e)) \
        begin \
            failures++; \
            $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); \
        end \
    end

    apb_master bus (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    dual_interval_timer_toggle dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_count_pin(ext_count_pin), .toggle_out_pin(toggle_out_pin),
        .toggle_timebase(toggle_timebase), .a_match_irq(a_match_irq),
        .b_match_irq(b_match_irq), .irq(irq));

    task finish_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        bus.xfer(1'h1, a, d, q, e);
    endtask

    task rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        bus.xfer(1'h0, a, 32'h0000_0000, q, e);
    endtask

    // cyc moves by non-blocking update, so every read at an edge sees the same count
    task wait_pulse(input logic b, output int at);
        do
            @(posedge clk);
        while ((b ? b_match_irq : a_match_irq) !== 1'h1);
        at = cyc;
    endtask

    task t_reset;
        logic [31:0] q;
        logic        e;
        rd(`ADDR_MODE, q);
        `CHECK(q, 32'h0000_00FF);
        rd(`ADDR_COUNT_A, q);
        `CHECK(q, 32'h0000_0000);
        rd(`ADDR_COUNT_B, q);
        `CHECK(q, 32'h0000_0000);
        `CHECK(toggle_out_pin, 1'h0);
        bus.xfer(1'h0, 12'h01C, 32'h0000_0000, q, e);
        `CHECK({e, q}, 33'h1_0000_0000);
    endtask

    task t_interval;
        int          t0, t1;
        logic        tg;
        logic [31:0] q;
        wr(`ADDR_COMPARE_A, 32'h0000_0003);
        wr(`ADDR_IRQ_MASK, 32'h0000_0001);
        wr(`ADDR_MODE, 32'h0000_00E0);
        wait_pulse(1'h0, t0);
        tg = toggle_out_pin;
        wait_pulse(1'h0, t1);
        `CHECK(t1 - t0, 3 * `DIV_MID);
        `CHECK(toggle_out_pin, ~tg);
        `CHECK(irq, 1'h1);
        rd(`ADDR_IRQ_STATUS, q);
        `CHECK(q, 32'h0000_0001);
        @(posedge clk);
        `CHECK(irq, 1'h0);
        wr(`ADDR_IRQ_MASK, 32'h0000_0000);
        wait_pulse(1'h0, t0);
        @(posedge clk);
        `CHECK(irq, 1'h0);
    endtask

    task t_restart;
        int          t0, t1;
        logic [31:0] c1, c2;
        wr(`ADDR_MODE, 32'h0000_00F0);
        wr(`ADDR_COMPARE_A, 32'h0000_0000);
        wr(`ADDR_MODE, 32'h0000_00E0);
        wait_pulse(1'h0, t0);
        repeat (200) @(posedge clk);
        rd(`ADDR_COUNT_A, c1);
        wr(`ADDR_MODE, 32'h0000_00E0);
        rd(`ADDR_COUNT_A, c2);
        `CHECK(c1 != 32'h0 && c2 >= c1, 1'h1);
        wait_pulse(1'h0, t1);
        `CHECK(t1 - t0, 32'h100 * `DIV_MID);
        wr(`ADDR_MODE, 32'h0000_00F0);
        rd(`ADDR_COUNT_A, c1);
        `CHECK(c1, 32'h0000_0000);
    endtask

    task t_suppress;
        logic [31:0] q;
        wr(`ADDR_COMPARE_A, 32'h0000_0001);
        wr(`ADDR_MODE, 32'h0000_00E0);
        repeat (24) @(posedge clk);
        rd(`ADDR_COUNT_A, q);
        `CHECK(q, 32'h0000_0000);
        // writes every fifth cycle against events every twelfth: one lands on an event
        repeat (12)
        begin
            wr(`ADDR_COMPARE_A, 32'h0000_0001);
            repeat (2) @(posedge clk);
        end
        rd(`ADDR_COUNT_A, q);
        `CHECK(q != 32'h0, 1'h1);
        wr(`ADDR_MODE, 32'h0000_00F0);
    endtask

    task t_slow;
        int t0, t1;
        wr(`ADDR_COMPARE_A, 32'h0000_0001);
        wr(`ADDR_MODE, 32'h0000_00E4);
        wait_pulse(1'h0, t0);
        wait_pulse(1'h0, t1);
        `CHECK(t1 - t0, `DIV_SLOW);
        wr(`ADDR_MODE, 32'h0000_00F0);
    endtask

    task t_cascade;
        int   t0, t1;
        logic tg;
        wr(`ADDR_COMPARE_B, 32'h0000_0002);
        wr(`ADDR_MODE, 32'h0000_0061);
        wait_pulse(1'h1, t0);
        tg = toggle_out_pin;
        wait_pulse(1'h1, t1);
        `CHECK(t1 - t0, 2 * `DIV_MID);
        `CHECK(toggle_out_pin, ~tg);
        wr(`ADDR_MODE, 32'h0000_00FE);
    endtask

    task t_div3;
        int   n;
        logic tg;
        n = 0;
        // skip one edge, which already runs under the div3 toggle source written at the previous edge
        @(posedge clk);
        tg = toggle_out_pin;
        repeat (30)
        begin
            @(posedge clk);
            if (toggle_out_pin !== tg)
                n++;
            tg = toggle_out_pin;
        end
        `CHECK(n, 30 / `DIV_FAST);
        wr(`ADDR_MODE, 32'h0000_00FF);
        repeat (2) @(posedge clk);
        `CHECK(toggle_out_pin, 1'h0);
    endtask

    task t_ext;
        logic [31:0] q;
        wr(`ADDR_COMPARE_A, 32'h0000_0000);
        wr(`ADDR_MODE, 32'h0000_00E8);
        repeat (3)
        begin
            repeat (12) @(posedge clk);
            ext_count_pin <= 1'h0;
            repeat (12) @(posedge clk);
            ext_count_pin <= 1'h1;
        end
        // one-cycle dips are shorter than two samples and must not count
        repeat (3)
        begin
            repeat (12) @(posedge clk);
            ext_count_pin <= 1'h0;
            @(posedge clk);
            ext_count_pin <= 1'h1;
        end
        repeat (12) @(posedge clk);
        rd(`ADDR_COUNT_A, q);
        `CHECK(q, 32'h0000_0003);
        wr(`ADDR_MODE, 32'h0000_00FF);
    endtask

    initial
    begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures++;
            finish_test;
        end
    end

    initial
    begin
        rst_b = 1'h0;
        ext_count_pin = 1'h1;
        failures = 0;
        checks_done = 0;
        cyc = 0;
        repeat (10) @(posedge clk);
        rst_b <= 1'h1;
        t_reset;
        t_interval;
        t_restart;
        t_suppress;
        t_slow;
        t_cascade;
        t_div3;
        t_ext;
        finish_test;
    end
endmodule // dual_interval_timer_toggle_tb
